/* shared/krrp_params.svh */
// constants shared by the key scanner and its controller
`ifndef KRRP_PARAMS_SVH
`define KRRP_PARAMS_SVH

// clock: 200 MHz
`define KRRP_CLK_NS      5
// clk cycles per oscillator period T
`define KRRP_OSC_DIV     4'h8
// scan timing in oscillator periods T (288T, 615T, 1230T)
`define KRRP_SCAN_T      11'h120
`define KRRP_AGREE_T     11'h267
`define KRRP_RESCAN_T    11'h4CE
// reset pin low time and settle time after it, least 10 us each
`define KRRP_RST_NS      10000
`define KRRP_RST_CYC     ((`KRRP_RST_NS + `KRRP_CLK_NS - 1) / `KRRP_CLK_NS)
// serial clock half period in clk cycles
`define KRRP_SCK_HALF    4'h8
// frame addresses, arbitrary values
`define KRRP_ADDR_WR     8'hA5
`define KRRP_ADDR_RD     8'h5A
// frame layout in bits
`define KRRP_ADDR_BITS   6'h08
`define KRRP_CTRL_BITS   6'h0C
`define KRRP_KEY_BITS    6'h1E
`define KRRP_CTRL_W      12
`define KRRP_KEY_W       30
// control data fields
`define KRRP_PC_LSB      0
`define KRRP_KC_LSB      4
`define KRRP_KP1_BIT     10
`define KRRP_KP2_BIT     11
// controller register offsets
`define KRRP_REG_CTRL    8'h00
`define KRRP_REG_MODE    8'h04
`define KRRP_REG_KEYS    8'h08
`define KRRP_REG_STAT    8'h0C
`define KRRP_REG_MASK    8'h10
`define KRRP_REG_STATE   8'h14
// status bits and mode bits
`define KRRP_ST_KEY      0
`define KRRP_ST_CTRL     1
`define KRRP_ST_INV      2
`define KRRP_MD_IRQ      0
`define KRRP_MD_RUN      1
// controller poll period and rearm delay defaults, clk cycles
`define KRRP_POLL_DEF    16'h2AF8
`define KRRP_REARM_DEF   16'h2904

`endif

/* shared/krrp_pkg.sv */
// types shared by the key scanner and its controller
`include "krrp_params.svh"
package krrp_pkg;
    typedef logic [5:0]  krrp_drv_t;
    typedef logic [4:0]  krrp_sense_t;
    typedef logic [7:0]  krrp_addr_t;
    typedef logic [31:0] krrp_word_t;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_SCAN = 2'b01,
        D_REQ  = 2'b10
    } krrp_dst_t;

    typedef enum logic [1:0] {
        H_BOOT = 2'b00,
        H_IDLE = 2'b01,
        H_XFER = 2'b10,
        H_GAP  = 2'b11
    } krrp_hst_t;
endpackage

/* shared/krrp_if.sv */
// three-wire serial link with open-drain request line
`timescale 1ns/100ps
interface krrp_if;
    logic rst_pin_n;
    logic ce;
    logic sclk;
    logic di;
    logic do_o;
    logic do_oe;
    wire  req_line;

    // pull-up: line reads high unless the scanner pulls it down
    assign req_line = do_oe ? do_o : 1'b1;

    modport dev  (input rst_pin_n, input ce, input sclk, input di,
                  output do_o, output do_oe);
    modport host (output rst_pin_n, output ce, output sclk, output di,
                  input req_line);
endinterface

/* design/krrp_dev.sv */
// key matrix scanner: reset, scan timing, request line, serial frames
//
// The implementer's own choices: the two frame address values, KRRP_ADDR_WR and KRRP_ADDR_RD.
`timescale 1ns/100ps
`include "krrp_params.svh"
module krrp_dev (
    input  wire logic              clk,
    input  wire logic              rst_n,
    krrp_if.dev                    bus,
    input  wire krrp_pkg::krrp_sense_t scan_sense_inputs,
    output krrp_pkg::krrp_drv_t        scan_drive_lines,
    output logic                   general_output_1
);
    import krrp_pkg::*;

    typedef struct packed {
        logic            rp1;
        logic            rp2;
        logic            ce1;
        logic            ce2;
        logic            ck1;
        logic            ck2;
        logic            di1;
        logic            di2;
        krrp_sense_t     k1;
        krrp_sense_t     k2;
        logic            ce_p;
        logic            ck_p;
        logic [11:0]     ctrl;
        logic            en;
        krrp_dst_t       st;
        logic            rnd;
        logic [3:0]      div;
        logic [10:0]     tcnt;
        logic [2:0]      row;
        logic [29:0]     acc;
        logic [29:0]     snap;
        logic [29:0]     keys;
        logic [5:0]      bcnt;
        logic [7:0]      addr;
        logic [29:0]     shf;
        logic            oe;
        krrp_drv_t       drv;
        logic            gp1;
    } krrp_dev_t;

    krrp_dev_t q;
    krrp_dev_t n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       rise;
        logic       fall;
        logic       tick;
        logic       rd;
        logic       fin;
        krrp_drv_t  gen;
        krrp_drv_t  kc;
        logic [3:0] pc;
        logic [7:0] anew;
        rise = 1'b0;
        fall = 1'b0;
        tick = 1'b0;
        rd   = 1'b0;
        fin  = 1'b0;
        gen  = '0;
        kc   = '0;
        pc   = '0;
        anew = '0;
        n    = q;

        kc   = q.ctrl[`KRRP_KC_LSB +: 6];
        pc   = q.ctrl[`KRRP_PC_LSB +: 4];
        // shared pins turn general from the last line downwards
        gen[5] = q.ctrl[`KRRP_KP1_BIT] | q.ctrl[`KRRP_KP2_BIT];
        gen[4] = q.ctrl[`KRRP_KP2_BIT];
        gen[3] = q.ctrl[`KRRP_KP1_BIT] & q.ctrl[`KRRP_KP2_BIT];

        rise = q.ce2 & q.ck2 & ~q.ck_p;
        fall = q.ce2 & ~q.ck2 & q.ck_p;
        rd   = (q.addr == `KRRP_ADDR_RD);
        anew = {q.di2, q.addr[7:1]};

        // serial frame: lsb first, address then data
        if (rise) begin
            if (q.bcnt < `KRRP_ADDR_BITS) begin
                n.addr = anew;
            end else if (!rd) begin
                n.shf = {q.di2, q.shf[29:1]};
            end
            // key data loaded whether or not a request is pending
            if (q.bcnt == `KRRP_ADDR_BITS - 6'h01 &&
                anew == `KRRP_ADDR_RD) begin
                n.shf = q.keys;
            end
            if (q.bcnt != 6'h3F) begin
                n.bcnt = q.bcnt + 6'h01;
            end
        end

        // request line and read data share the open-drain pin
        if (q.ce2) begin
            if (fall && rd && q.bcnt >= `KRRP_ADDR_BITS) begin
                n.oe  = ~q.shf[0];
                n.shf = {1'b0, q.shf[29:1]};
            end else if (!rd || q.bcnt < `KRRP_ADDR_BITS) begin
                n.oe = 1'b0;
            end
        end else begin
            n.oe = (q.st == D_REQ);
        end

        // oscillator runs only while a scan is in progress
        if (q.st == D_SCAN) begin
            tick  = (q.div == `KRRP_OSC_DIV - 4'h1);
            n.div = tick ? 4'h0 : q.div + 4'h1;
        end else begin
            n.div = 4'h0;
        end

        case (q.st)
            D_IDLE: begin
                // a pressed key on a high line shows on the sense inputs
                if (q.en && |q.k2) begin
                    n.st   = D_SCAN;
                    n.tcnt = 11'h000;
                    n.row  = 3'h0;
                    n.rnd  = 1'b0;
                    n.acc  = '0;
                end
            end
            D_SCAN: begin
                if (tick) begin
                    for (int r = 0; r < 6; r++) begin
                        if (q.row == 3'(r)) begin
                            n.acc[r*5 +: 5] = (kc[r] & ~gen[r]) ?
                                              q.k2 : 5'h00;
                        end
                    end
                    n.row  = (q.row == 3'h5) ? 3'h0 : q.row + 3'h1;
                    n.tcnt = q.tcnt + 11'h001;
                    if (q.tcnt == `KRRP_SCAN_T - 11'h001 ||
                        (q.rnd && q.tcnt ==
                         `KRRP_AGREE_T + `KRRP_SCAN_T - 11'h001)) begin
                        n.snap = q.acc;
                    end
                    if (q.tcnt == `KRRP_AGREE_T - 11'h001) begin
                        if (q.acc == q.snap) begin
                            fin = 1'b1;
                        end else begin
                            n.rnd = 1'b1;
                        end
                    end
                    if (q.tcnt == `KRRP_RESCAN_T - 11'h001) begin
                        fin = 1'b1;
                    end
                end
                if (fin) begin
                    n.keys = q.acc;
                    // all keys released: back to standby with no request
                    n.st   = (|q.acc) ? D_REQ : D_IDLE;
                end
            end
            D_REQ: begin
                n.st = D_REQ;
            end
            default: begin
                n.st = D_IDLE;
            end
        endcase

        // frame end on falling chip enable
        if (!q.ce2 && q.ce_p) begin
            if (q.addr == `KRRP_ADDR_WR &&
                q.bcnt == `KRRP_ADDR_BITS + `KRRP_CTRL_BITS) begin
                n.ctrl = q.shf[`KRRP_KEY_W-1 -: `KRRP_CTRL_W];
                n.en   = 1'b1;
            end
            if (rd && q.st == D_REQ) begin
                n.st   = D_SCAN;
                n.oe   = 1'b0;
                n.tcnt = 11'h000;
                n.row  = 3'h0;
                n.rnd  = 1'b0;
                n.acc  = '0;
            end
            n.bcnt = 6'h00;
            n.addr = 8'h00;
        end

        // standby levels, scan row, or general data on shared pins
        for (int i = 0; i < 6; i++) begin
            if (gen[i]) begin
                // only lines 4..6 can turn general, so two bits index
                n.drv[i] = pc[2'(6 - i)];
            end else if (q.st == D_SCAN) begin
                n.drv[i] = kc[i] & (q.row == 3'(i));
            end else begin
                n.drv[i] = kc[i];
            end
        end
        n.gp1 = pc[0];

        // reset pin: everything to its initial state, clock stopped
        if (!q.rp2) begin
            n = '0;
        end

        n.rp1  = bus.rst_pin_n;
        n.rp2  = q.rp1;
        n.ce1  = bus.ce;
        n.ce2  = q.ce1;
        n.ck1  = bus.sclk;
        n.ck2  = q.ck1;
        n.di1  = bus.di;
        n.di2  = q.di1;
        n.k1   = scan_sense_inputs;
        n.k2   = q.k1;
        n.ce_p = q.ce2;
        n.ck_p = q.ck2;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign scan_drive_lines = q.drv;
    assign general_output_1 = q.gp1;
    // open drain: only ever pulls low
    assign bus.do_o         = 1'b0;
    assign bus.do_oe        = q.oe;
endmodule

/* design/krrp_host.sv */
// controller: resets the scanner, sends control data, collects keys
`timescale 1ns/100ps
`include "krrp_params.svh"
module krrp_host #(
    parameter logic [15:0] POLL_CYC  = `KRRP_POLL_DEF,
    parameter logic [15:0] REARM_CYC = `KRRP_REARM_DEF
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    krrp_if.host                    bus,
    input  wire krrp_pkg::krrp_addr_t reg_addr,
    input  wire krrp_pkg::krrp_word_t reg_wdata,
    input  wire logic               reg_we,
    input  wire logic               reg_re,
    output krrp_pkg::krrp_word_t      reg_rdata,
    output logic                    irq
);
    import krrp_pkg::*;

    typedef struct packed {
        logic        rq1;
        logic        rq2;
        logic [11:0] rcnt;
        logic        prst_n;
        logic [11:0] ctrl;
        logic [1:0]  mode;
        logic        wpend;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic        irq;
        logic [29:0] keys;
        logic [29:0] rx;
        krrp_hst_t   st;
        logic        isrd;
        logic        pend;
        logic [19:0] tx;
        logic [5:0]  bcnt;
        logic [3:0]  hc;
        logic [15:0] poll;
        logic        pdue;
        logic [15:0] rearm;
        logic        ce;
        logic        sclk;
        logic        di;
        krrp_word_t  rdata;
    } krrp_host_t;

    krrp_host_t q;
    krrp_host_t n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [2:0] set;
        logic [2:0] clr;
        logic       go;
        set  = 3'h0;
        clr  = 3'h0;
        go   = 1'b0;
        n    = q;
        n.rq1 = bus.req_line;
        n.rq2 = q.rq1;
        n.rdata = 32'h0000_0000;

        if (q.st != H_BOOT) begin
            n.poll = (q.poll == 16'h0000) ? POLL_CYC - 16'h0001 :
                                            q.poll - 16'h0001;
            if (q.poll == 16'h0000) begin
                n.pdue = 1'b1;
            end
            if (q.rearm != 16'h0000) begin
                n.rearm = q.rearm - 16'h0001;
            end
        end

        case (q.st)
            H_BOOT: begin
                // pin low, then let the scanner settle before any frame
                n.rcnt   = q.rcnt + 12'h001;
                n.prst_n = (q.rcnt >= 12'(`KRRP_RST_CYC));
                if (q.rcnt == 12'(2 * `KRRP_RST_CYC - 1)) begin
                    n.st = H_IDLE;
                end
            end
            H_IDLE: begin
                if (q.wpend) begin
                    // every shared pin mode bit goes out each time
                    n.tx    = {q.ctrl, `KRRP_ADDR_WR};
                    n.isrd  = 1'b0;
                    n.wpend = 1'b0;
                    go      = 1'b1;
                end else if (q.mode[`KRRP_MD_RUN]) begin
                    if (!q.mode[`KRRP_MD_IRQ] && q.pdue) begin
                        n.pdue = 1'b0;
                        go     = ~q.rq2;
                    end else if (q.mode[`KRRP_MD_IRQ] &&
                                 q.rearm == 16'h0000) begin
                        go = ~q.rq2;
                    end
                    n.tx   = {12'h000, `KRRP_ADDR_RD};
                    n.isrd = 1'b1;
                end
                if (go) begin
                    n.st   = H_XFER;
                    n.ce   = 1'b1;
                    n.di   = n.tx[0];
                    n.bcnt = 6'h00;
                    n.hc   = 4'h0;
                    n.pend = ~q.rq2;
                end
            end
            H_XFER: begin
                n.hc = q.hc + 4'h1;
                if (q.hc == `KRRP_SCK_HALF - 4'h1) begin
                    n.hc   = 4'h0;
                    n.sclk = ~q.sclk;
                    if (q.sclk) begin
                        if (q.isrd && q.bcnt >= `KRRP_ADDR_BITS) begin
                            n.rx = {q.rq2, q.rx[29:1]};
                        end
                        if (q.bcnt == `KRRP_ADDR_BITS - 6'h01 +
                            (q.isrd ? `KRRP_KEY_BITS : `KRRP_CTRL_BITS))
                        begin
                            n.st = H_GAP;
                            n.ce = 1'b0;
                            n.di = 1'b0;
                        end else begin
                            n.bcnt = q.bcnt + 6'h01;
                            n.tx   = {1'b0, q.tx[19:1]};
                            n.di   = q.tx[1];
                        end
                    end
                end
            end
            H_GAP: begin
                n.hc = q.hc + 4'h1;
                if (q.hc == 4'h0) begin
                    if (!q.isrd) begin
                        set[`KRRP_ST_CTRL] = 1'b1;
                    end else if (q.pend) begin
                        n.keys = q.rx;
                        set[`KRRP_ST_KEY] = 1'b1;
                    end else begin
                        set[`KRRP_ST_INV] = 1'b1;
                    end
                    if (q.isrd) begin
                        n.rearm = REARM_CYC;
                    end
                end
                if (q.hc == `KRRP_SCK_HALF - 4'h1) begin
                    n.st = H_IDLE;
                end
            end
            default: begin
                n.st = H_BOOT;
            end
        endcase

        if (reg_we) begin
            case (reg_addr)
                `KRRP_REG_CTRL: begin
                    n.ctrl  = reg_wdata[`KRRP_CTRL_W-1:0];
                    n.wpend = 1'b1;
                end
                `KRRP_REG_MODE: n.mode = reg_wdata[1:0];
                `KRRP_REG_STAT: clr = reg_wdata[2:0];
                `KRRP_REG_MASK: n.mask = reg_wdata[2:0];
                default: begin
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        n.stat = (q.stat & ~clr) | set;
        n.irq  = |(n.stat & n.mask);

        if (reg_re) begin
            case (reg_addr)
                `KRRP_REG_CTRL:  n.rdata = {20'h00000, q.ctrl};
                `KRRP_REG_MODE:  n.rdata = {30'h0, q.mode};
                `KRRP_REG_KEYS:  n.rdata = {2'h0, q.keys};
                `KRRP_REG_STAT:  n.rdata = {29'h0, q.stat};
                `KRRP_REG_MASK:  n.rdata = {29'h0, q.mask};
                `KRRP_REG_STATE: n.rdata = {29'h0, q.wpend, q.rq2,
                                            q.st != H_IDLE};
                default:         n.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign bus.rst_pin_n = q.prst_n;
    assign bus.ce        = q.ce;
    assign bus.sclk      = q.sclk;
    assign bus.di        = q.di;
    assign reg_rdata     = q.rdata;
    assign irq           = q.irq;
endmodule

/* sim/krrp_monitor.sv */
// link checks between the controller and the scanner
`timescale 1ns/100ps
`include "krrp_params.svh"
module krrp_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rst_pin_n,
    input wire logic ce,
    input wire logic sclk,
    input wire logic di,
    input wire logic do_o,
    input wire logic do_oe,
    input wire logic req_line
);
    // one edge of slack for where the low count starts
    localparam logic [15:0] RST_MIN = 16'(`KRRP_RST_CYC - 1);
    logic [5:0]  bits_q;
    logic [7:0]  addr_q;
    logic [15:0] low_q;
    logic        ctl_q;
    logic        sclk_q;
    logic        ce_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_q <= '0;
            addr_q <= '0;
            low_q  <= '0;
            ctl_q  <= 1'b0;
            sclk_q <= 1'b0;
            ce_q   <= 1'b0;
        end else begin
            sclk_q <= sclk;
            ce_q   <= ce;
            low_q  <= rst_pin_n ? 16'h0000 : low_q + 16'h0001;
            if (!ce) begin
                bits_q <= '0;
            end else if (sclk && !sclk_q) begin
                bits_q <= bits_q + 6'h01;
                if (bits_q < 6'h08)
                    addr_q[bits_q[2:0]] <= di;
            end
            if (!rst_pin_n)
                ctl_q <= 1'b0;
            else if (ce_q && !ce && addr_q == `KRRP_ADDR_WR)
                ctl_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rst_req_a: assert property (
        !rst_pin_n && !$past(rst_pin_n, 4) |-> !do_oe)
        else $error("request pulled during scanner reset");
    od_level_a: assert property (
        do_oe |-> do_o == 1'b0 && req_line == 1'b0)
        else $error("request line not pulled low");
    rst_len_a: assert property (
        $rose(rst_pin_n) |-> low_q >= RST_MIN)
        else $error("scanner reset pulse too short");
    rst_ce_a: assert property (
        !rst_pin_n |-> !ce && !sclk)
        else $error("frame during scanner reset");
    addr_rel_a: assert property (
        ce && $past(ce, 4) && (bits_q < 6'h08 ||
        addr_q == `KRRP_ADDR_WR) |-> !do_oe)
        else $error("request pulled inside a frame");
    frame_len_a: assert property (
        $fell(ce) |-> bits_q == ((addr_q == `KRRP_ADDR_WR) ?
        6'h14 : 6'h26))
        else $error("frame bit count wrong");
    frame_gap_a: assert property (
        $fell(ce) |=> !ce [*7])
        else $error("frames too close");
    half_per_a: assert property (
        ce && $rose(sclk) |=> sclk [*7])
        else $error("serial clock high half too short");
    rd_release_a: assert property (
        $fell(ce) && addr_q == `KRRP_ADDR_RD |-> ##5 !do_oe [*8])
        else $error("request kept after key read");
    pre_ctl_a: assert property (
        !ctl_q && !ce && !$past(ce, 4) |-> !do_oe)
        else $error("request before control data");
endmodule

/* sim/tb.sv */
// bench: controller and scanner joined over the serial link
`timescale 1ns/100ps
`include "krrp_params.svh"
module tb;
    import krrp_pkg::*;
    logic        clk;
    logic        rst_n;
    krrp_addr_t  reg_addr;
    krrp_word_t  reg_wdata;
    logic        reg_we;
    logic        reg_re;
    krrp_word_t  reg_rdata;
    logic        irq;
    krrp_sense_t sense;
    krrp_drv_t   lines;
    logic        gp1;
    logic [29:0] keys_q;
    logic [11:0] ctl;
    krrp_word_t  exp_q[$];
    krrp_word_t  rv;
    int          error_cnt;
    int          compares;
    int          cyc;
    int          seed;
    int          ka;
    int          kb;

    krrp_if link ();
    krrp_host krrp_host_i (.clk(clk), .rst_n(rst_n), .bus(link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));
    krrp_dev krrp_dev_i (.clk(clk), .rst_n(rst_n), .bus(link),
        .scan_sense_inputs(sense), .scan_drive_lines(lines),
        .general_output_1(gp1));
    krrp_monitor krrp_monitor_i (.clk(clk), .rst_n(rst_n),
        .rst_pin_n(link.rst_pin_n), .ce(link.ce), .sclk(link.sclk),
        .di(link.di), .do_o(link.do_o), .do_oe(link.do_oe),
        .req_line(link.req_line));

    ////////////////////////////////////////////////////////////////////////
    // key matrix: a pressed key joins its drive line to its sense input
    always_comb begin
        sense = '0;
        for (int r = 0; r < 6; r++)
            for (int c = 0; c < 5; c++)
                sense[c] = sense[c] | (keys_q[r * 5 + c] & lines[r]);
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input krrp_word_t seen, input krrp_word_t exp,
                       input string what);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input krrp_addr_t a, input krrp_word_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    task automatic rd(input krrp_addr_t a, output krrp_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_stat(input int b);
        int n;
        n = 0;
        rv = '0;
        while (rv[b] !== 1'b1 && n < 12000) begin
            rd(`KRRP_REG_STAT, rv);
            n++;
        end
        chk(rv[b], 1'b1, "status bit");
    endtask

    // standby levels; shared pins turn general from line 6 downwards
    function automatic krrp_drv_t exp_lines(input logic [11:0] c);
        krrp_drv_t l;
        int        n;
        l = c[9:4];
        n = {c[`KRRP_KP2_BIT], c[`KRRP_KP1_BIT]};
        if (n >= 1) l[5] = c[1];
        if (n >= 2) l[4] = c[2];
        if (n >= 3) l[3] = c[3];
        return l;
    endfunction

    // press key a, switch to key b at 400T, expect a request after t periods
    task automatic scan(input logic irqm, input int a, input int b,
                        input int t);
        int n;
        wr(`KRRP_REG_MODE, {30'h0, 1'b1, irqm});
        wr(`KRRP_REG_MASK, {31'h0, irqm});
        exp_q.push_back(32'h1 << b);
        @(posedge clk);
        keys_q <= 30'h1 << a;
        n = 0;
        while (!(link.req_line === 1'b0 && link.ce === 1'b0) && n < 12000) begin
            @(posedge clk);
            n++;
            if (n == 400 * 8)
                keys_q <= 30'h1 << b;
        end
        chk(n >= t * 8 && n <= t * 8 + 24, 1'b1, "request time");
        keys_q <= '0;
        wait_stat(`KRRP_ST_KEY);
        chk(rv[`KRRP_ST_INV], 1'b0, "invalid read flag");
        rd(`KRRP_REG_KEYS, rv);
        chk(rv, exp_q.pop_front(), "key data");
        chk(irq, irqm, "irq level");
        wr(`KRRP_REG_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "irq clear");
        // the rescan after the read must find no keys and settle
        repeat (615 * 8 + 100) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n     = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
        keys_q    = '0;
        error_cnt = 0;
        compares  = 0;
        cyc       = 0;
        seed      = 32'hd0e45c4e;
        repeat (3) @(posedge clk);
        chk(lines, '0, "lines in reset");
        chk(link.req_line, 1'b1, "request in reset");
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (1000) @(posedge clk);
        chk(lines, '0, "lines in scanner reset");
        chk(gp1, 1'b0, "general in scanner reset");
        chk(link.req_line, 1'b1, "request in scanner reset");
        repeat (3100) @(posedge clk);
        chk(lines, '0, "lines after reset");
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, rv);
        chk(rv, '0, "unmapped");
        for (int m = 0; m < 5; m++) begin
            ctl = (m < 4) ? {m[1:0], 10'({$random(seed)})} : 12'h3F0;
            wr(`KRRP_REG_CTRL, {20'h0, ctl});
            wait_stat(`KRRP_ST_CTRL);
            wr(`KRRP_REG_STAT, 32'h2);
            repeat (8) @(posedge clk);
            chk(lines, exp_lines(ctl), "standby lines");
            chk(gp1, ctl[`KRRP_PC_LSB], "general output");
            rd(`KRRP_REG_CTRL, rv);
            chk(rv, {20'h0, ctl}, "control readback");
            // idle link: no control pending, request released, not busy
            rd(`KRRP_REG_STATE, rv);
            chk(rv, 32'h0000_0002, "link state");
        end
        ka = {$random(seed)} % 30;
        kb = (ka + 1 + {$random(seed)} % 29) % 30;
        scan(1'b0, ka, ka, 615);
        scan(1'b1, kb, kb, 615);
        scan(1'b1, ka, kb, 1230);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(lines, '0, "lines in second reset");
        chk(gp1, 1'b0, "general in second reset");
        chk(link.req_line, 1'b1, "request in second reset");
        rst_n <= 1'b1;
        repeat (4100) @(posedge clk);
        rd(`KRRP_REG_CTRL, rv);
        chk(rv, '0, "control after reset");
        chk(lines, '0, "lines after second reset");
        end_sim();
    end
endmodule
